// [src/sqd_pkg.sv]
// Shared constants and types of the squib deploy control block
package sqd_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;

  // ---------------------------------------------------------------
  // Timing figures in their own units
  // ---------------------------------------------------------------
  localparam int unsigned T_DUR_500US_NS = 500000;
  localparam int unsigned T_DUR_700US_NS = 700000;
  localparam int unsigned T_DUR_2MS_NS = 2000000;
  localparam int unsigned T_EXP_SPAN_MS = 500;
  localparam int unsigned EXP_STEPS = 63;
  localparam int unsigned T_DEL_SD_LS_NS = 2000;
  localparam int unsigned T_FLT_ILIM_LS_NS = 4000;
  localparam int unsigned T_ARM_STRETCH_US = 1000;

  // ---------------------------------------------------------------
  // Cycle counts derived from the figures
  // ---------------------------------------------------------------
  localparam int unsigned DUR_500US_CYC = (T_DUR_500US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DUR_700US_CYC = (T_DUR_700US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DUR_2MS_CYC = (T_DUR_2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXP_TICK_CYC = (T_EXP_SPAN_MS * 1000000 / EXP_STEPS) / CLK_PERIOD_NS;
  localparam int unsigned DEL_LS_CYC = (T_DEL_SD_LS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLT_ILIM_CYC = (T_FLT_ILIM_LS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ARM_STRETCH_CYC = (T_ARM_STRETCH_US * 1000) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned EXP_W = 6;
  localparam int unsigned TICK_W = 19;
  localparam int unsigned STR_W = 20;
  localparam int unsigned FLT_W = 10;
  localparam int unsigned DUR_W = 17;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DUR_SEL_500US = 2'h0;
  localparam logic [1:0] DUR_SEL_700US = 2'h1;
  localparam logic [1:0] DUR_SEL_2MS = 2'h2;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [EXP_W-1:0] EXP_RST = 6'h00;
  localparam logic [5:0] SYNC_RST = 6'h02;

  typedef enum logic
  {
    GFE_OFF = 1'b0,
    GFE_ON = 1'b1
  } sqd_gfe_t;

endpackage

// [src/sqd_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sqd_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] P_RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sqd_sync_state_t;

  sqd_sync_state_t q;
  sqd_sync_state_t d;

  always_comb
  begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Output follows only where stages two and three agree
    d.o = (q.s2 & q.s3) | (q.o & (q.s2 | q.s3));
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= {P_RST, P_RST, P_RST, P_RST};
    end
    else
    begin
      q <= d;
    end
  end

  assign sync_out = q.o;

endmodule

// [src/sqd_fire_chan.sv]
// One deployment channel: firing timer and staged driver turn-off
`timescale 1ns/1ps
module sqd_fire_chan #(
  parameter int unsigned P_DUR_500 = sqd_pkg::DUR_500US_CYC,
  parameter int unsigned P_DUR_700 = sqd_pkg::DUR_700US_CYC,
  parameter int unsigned P_DUR_2MS = sqd_pkg::DUR_2MS_CYC,
  parameter int unsigned P_DEL_LS = sqd_pkg::DEL_LS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [1:0] dur_sel,
  input wire logic abort,
  // Drivers and status
  output logic hs_on,
  output logic ls_on,
  output logic done,
  output logic busy
);

  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_FIRE = 2'b01,
    CH_LSDLY = 2'b10
  } sqd_chan_st_t;

  typedef struct packed {
    sqd_chan_st_t st;
    logic [sqd_pkg::DUR_W-1:0] cnt;
    logic hs;
    logic ls;
    logic done;
  } sqd_chan_state_t;

  sqd_chan_state_t q;
  sqd_chan_state_t d;
  logic [sqd_pkg::DUR_W-1:0] dur_load;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (dur_sel == sqd_pkg::DUR_SEL_2MS)
      dur_load = sqd_pkg::DUR_W'(P_DUR_2MS - 1);
    else if (dur_sel == sqd_pkg::DUR_SEL_700US)
      dur_load = sqd_pkg::DUR_W'(P_DUR_700 - 1);
    else
      dur_load = sqd_pkg::DUR_W'(P_DUR_500 - 1);
    unique case (q.st)
      CH_IDLE:
      begin
        if (start && !abort)
        begin
          d.st = CH_FIRE;
          d.cnt = dur_load;
          d.hs = 1'b1;
          d.ls = 1'b1;
        end
      end
      CH_FIRE:
      begin
        // R4 only elapse, fault abort or reset ends
        if (q.cnt == '0)
        begin
          // R22 success on elapse
          d.done = 1'b1;
          d.hs = 1'b0;
          d.st = CH_LSDLY;
          d.cnt = sqd_pkg::DUR_W'(P_DEL_LS - 1);
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      CH_LSDLY:
      begin
        // R23 low side later
        if (q.cnt == '0)
        begin
          d.ls = 1'b0;
          d.st = CH_IDLE;
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default:
      begin
        d.st = CH_IDLE;
        d.hs = 1'b0;
        d.ls = 1'b0;
      end
    endcase
    // R24 latched fault shutdown
    if (abort)
    begin
      d.st = CH_IDLE;
      d.hs = 1'b0;
      d.ls = 1'b0;
      d.done = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '{st: CH_IDLE, cnt: '0, hs: 1'b0, ls: 1'b0, done: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign hs_on = q.hs;
  assign ls_on = q.ls;
  assign done = q.done;
  assign busy = (q.st != CH_IDLE);

endmodule

// [src/sqd_deploy_ctrl.sv]
// Squib deploy command, enable and channel control logic
//
// Operation
// R1: Four channels, separate high and low drivers.
// R2: Fire needs deploy command plus enabling condition.
// R3: High enable active high, low enable active low.
// R4: Started deployment stops only by elapse, fault or reset.
// R5: Any channel mix fires together or sequenced.
// R6: 1.75 A with 2 ms becomes 1.2 A 500us.
// R7: Replaced pairing sets the channel misuse flag.
// R8: Deploy command lapses after chosen hold period.
// R9: Six-bit expiration timer, readable with state.
// R10: Fire only with power good, safing or arming.
// R11: Host request bits trigger individual channels.
// R12: Fire also needs global enable on.
// R13: Refire needs global off-on toggle, new command.
// R14: Commands ignored while off and none pending.
// R15: Global on forces diagnostics to reset.
// R16: Lock and unlock command drives global enable.
// R17: Enables global, deploy commands per channel.
// R18: Enable accepted before, during, or after commands.
// R19: Unarmed command cancelled at timer expiry.
// R20: Lone arming holds enables for stretch time.
// R21: Stretch timer state is readable by host.
// R22: Elapsed timer sets channel and global success.
// R23: Low side turns off delayed after high.
// R24: Long current limit latches both drivers off.
// R25: Global enable resets off, moves on commands.
// R26: Timer loads on accept, clears pending at zero.
`timescale 1ns/1ps
module sqd_deploy_ctrl #(
  parameter int unsigned P_DUR_500 = sqd_pkg::DUR_500US_CYC,
  parameter int unsigned P_DUR_700 = sqd_pkg::DUR_700US_CYC,
  parameter int unsigned P_DUR_2MS = sqd_pkg::DUR_2MS_CYC,
  parameter int unsigned P_EXP_TICK = sqd_pkg::EXP_TICK_CYC,
  parameter int unsigned P_ARM_STRETCH = sqd_pkg::ARM_STRETCH_CYC,
  parameter int unsigned P_DEL_LS = sqd_pkg::DEL_LS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Device status from same clock domain
  input wire logic por_ok,
  input wire logic safing_state_machine_ok,
  input wire logic use_internal_safing,
  input wire logic arm_hs_pulse,
  input wire logic arm_ls_pulse,
  // Fire enable pins and current limit comparators
  input wire logic hs_fire_enable_in,
  input wire logic ls_fire_enable_n_in,
  input wire logic [3:0] ls_ilim_in,
  // Deploy command register write
  input wire logic deploy_command_wr,
  input wire logic [3:0] deploy_command_reg,
  // Global fire enable command
  input wire logic global_fire_enable_cmd,
  input wire logic global_fire_enable_signal,
  // Deploy configuration register write
  input wire logic deploy_config_wr,
  input wire logic [3:0] deploy_config_chan,
  input wire logic deploy_config_cur_hi,
  input wire logic [1:0] deploy_config_dur,
  input wire logic [5:0] deploy_config_hold,
  input wire logic [3:0] misuse_clr,
  // Drivers
  output logic [3:0] hs_drive,
  output logic [3:0] ls_drive,
  output logic [3:0] chan_cur_hi,
  // Deploy status
  output logic [3:0] deploy_pending,
  output logic [5:0] expire_timer,
  output logic [3:0] chan_deploy_misuse_flag,
  output logic [3:0] chan_deploy_done_flag,
  output logic any_deploy_done_flag,
  output logic [3:0] chan_fault_latched,
  output logic global_fire_on,
  output logic diag_force_reset,
  output logic [1:0] arm_stretch_status_reg,
  output logic hs_enable,
  output logic ls_enable
);

  localparam int unsigned NC = sqd_pkg::NUM_CHAN;

  typedef struct packed {
    sqd_pkg::sqd_gfe_t gfe;
    logic [NC-1:0] pend;
    logic [sqd_pkg::EXP_W-1:0] exp_cnt;
    logic [sqd_pkg::TICK_W-1:0] tick_cnt;
    logic [NC-1:0] fired;
    logic [NC-1:0] start;
    logic [NC-1:0] flt_latch;
    logic [NC-1:0][sqd_pkg::FLT_W-1:0] flt_cnt;
    logic [NC-1:0] cur_hi;
    logic [NC-1:0][1:0] dur_sel;
    logic [NC-1:0] misuse;
    logic [NC-1:0] done;
    logic any_done;
    logic [sqd_pkg::STR_W-1:0] hs_str;
    logic [sqd_pkg::STR_W-1:0] ls_str;
    logic [1:0] str_stat;
    logic hs_en;
    logic ls_en;
    logic diag_force;
  } sqd_top_state_t;

  sqd_top_state_t q;
  sqd_top_state_t d;

  logic [5:0] sync_out;
  logic hs_pin_s;
  logic ls_pin_n_s;
  logic [NC-1:0] ilim_s;
  logic [NC-1:0] chan_hs;
  logic [NC-1:0] chan_ls;
  logic [NC-1:0] chan_done;
  logic [NC-1:0] chan_busy;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  sqd_sync3 #(
    .W(6),
    .P_RST(sqd_pkg::SYNC_RST)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({ls_ilim_in, ls_fire_enable_n_in, hs_fire_enable_in}),
    .sync_out(sync_out)
  );

  assign hs_pin_s = sync_out[0];
  assign ls_pin_n_s = sync_out[1];
  assign ilim_s = sync_out[5:2];

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  // R1 four independent channels
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_chan
      sqd_fire_chan #(
        .P_DUR_500(P_DUR_500),
        .P_DUR_700(P_DUR_700),
        .P_DUR_2MS(P_DUR_2MS),
        .P_DEL_LS(P_DEL_LS)
      ) u_chan (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(q.start[gi]),
        .dur_sel(q.dur_sel[gi]),
        .abort(q.flt_latch[gi]),
        .hs_on(chan_hs[gi]),
        .ls_on(chan_ls[gi]),
        .done(chan_done[gi]),
        .busy(chan_busy[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control logic
  // ---------------------------------------------------------------
  logic hs_act;
  logic ls_act;
  logic accept;
  logic fire_ok;
  logic [NC-1:0] ready;

  always_comb
  begin
    d = q;

    // R16 global enable command
    // R25 changes only on command
    if (global_fire_enable_cmd)
    begin
      d.gfe = global_fire_enable_signal ? sqd_pkg::GFE_ON : sqd_pkg::GFE_OFF;
    end
    // R13 toggle rearms channels
    if (q.gfe == sqd_pkg::GFE_ON && d.gfe == sqd_pkg::GFE_OFF)
    begin
      d.fired = '0;
      d.flt_latch = '0;
    end
    // R15 diagnostics held in reset
    d.diag_force = (d.gfe == sqd_pkg::GFE_ON);

    // R20 arming pulse stretch
    if (arm_hs_pulse)
      d.hs_str = sqd_pkg::STR_W'(P_ARM_STRETCH - 1);
    else if (q.hs_str != '0)
      d.hs_str = q.hs_str - 1'b1;
    if (arm_ls_pulse)
      d.ls_str = sqd_pkg::STR_W'(P_ARM_STRETCH - 1);
    else if (q.ls_str != '0)
      d.ls_str = q.ls_str - 1'b1;
    hs_act = arm_hs_pulse || (q.hs_str != '0);
    ls_act = arm_ls_pulse || (q.ls_str != '0);
    // R21 stretch status
    d.str_stat = {ls_act, hs_act};
    // R3 pin polarities
    // R17 enables shared by all
    d.hs_en = use_internal_safing ? hs_act : hs_pin_s;
    d.ls_en = use_internal_safing ? ls_act : !ls_pin_n_s;

    // R6 forbidden pairing replaced
    d.misuse = q.misuse & ~misuse_clr;
    if (deploy_config_wr)
    begin
      d.tick_cnt = q.tick_cnt;
      for (int i = 0; i < NC; i++)
      begin
        if (deploy_config_chan[i])
        begin
          if (deploy_config_cur_hi && deploy_config_dur == sqd_pkg::DUR_SEL_2MS)
          begin
            d.cur_hi[i] = 1'b0;
            d.dur_sel[i] = sqd_pkg::DUR_SEL_500US;
            // R7 misuse flag set
            d.misuse[i] = 1'b1;
          end
          else
          begin
            d.cur_hi[i] = deploy_config_cur_hi;
            d.dur_sel[i] = deploy_config_dur;
          end
        end
      end
    end

    // R8 hold period countdown
    // R19 unarmed command lapses
    if (q.exp_cnt != '0)
    begin
      if (q.tick_cnt == sqd_pkg::TICK_W'(P_EXP_TICK - 1))
      begin
        d.tick_cnt = '0;
        d.exp_cnt = q.exp_cnt - 1'b1;
        // R26 clear at zero
        if (q.exp_cnt == sqd_pkg::EXP_W'(1))
          d.pend = '0;
      end
      else
      begin
        d.tick_cnt = q.tick_cnt + 1'b1;
      end
    end

    // R14 ignored while off, none pending
    accept = deploy_command_wr && (deploy_command_reg != '0)
      && (q.gfe == sqd_pkg::GFE_ON || q.pend != '0);
    if (accept)
    begin
      // R11 per channel triggers
      d.pend = d.pend | deploy_command_reg;
      // R26 timer load on accept
      d.exp_cnt = (deploy_config_hold == '0) ? sqd_pkg::EXP_W'(1) : deploy_config_hold;
      d.tick_cnt = '0;
    end

    // R2 command and enabling condition
    // R10 power and safing state
    // R12 global enable on
    // R18 coincidence in any order
    fire_ok = q.hs_en && q.ls_en && por_ok && safing_state_machine_ok
      && (q.gfe == sqd_pkg::GFE_ON);
    ready = q.pend & ~q.fired & ~q.flt_latch & ~chan_busy & ~q.start;
    // R5 any channel combination
    d.start = fire_ok ? ready : '0;
    d.fired = d.fired | d.start;
    d.pend = d.pend & ~d.start;
    if (d.pend == '0 && q.pend != '0)
    begin
      d.exp_cnt = '0;
      d.tick_cnt = '0;
    end

    // R24 current limit deglitch
    for (int i = 0; i < NC; i++)
    begin
      if (chan_busy[i] && ilim_s[i] && !q.flt_latch[i])
      begin
        if (q.flt_cnt[i] == sqd_pkg::FLT_W'(sqd_pkg::FLT_ILIM_CYC - 1))
        begin
          d.flt_latch[i] = 1'b1;
          d.flt_cnt[i] = '0;
        end
        else
        begin
          d.flt_cnt[i] = q.flt_cnt[i] + 1'b1;
        end
      end
      else
      begin
        d.flt_cnt[i] = '0;
      end
    end

    // R22 success flags
    d.done = q.done | chan_done;
    d.any_done = |(q.done | chan_done);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '{
        gfe: sqd_pkg::GFE_OFF,
        pend: sqd_pkg::CHAN_RST,
        exp_cnt: sqd_pkg::EXP_RST,
        tick_cnt: '0,
        fired: sqd_pkg::CHAN_RST,
        start: sqd_pkg::CHAN_RST,
        flt_latch: sqd_pkg::CHAN_RST,
        flt_cnt: '0,
        cur_hi: sqd_pkg::CHAN_RST,
        dur_sel: '0,
        misuse: sqd_pkg::CHAN_RST,
        done: sqd_pkg::CHAN_RST,
        any_done: 1'b0,
        hs_str: '0,
        ls_str: '0,
        str_stat: 2'h0,
        hs_en: 1'b0,
        ls_en: 1'b0,
        diag_force: 1'b0
      };
    end
    else
    begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hs_drive = chan_hs;
  assign ls_drive = chan_ls;
  assign chan_cur_hi = q.cur_hi;
  // R9 timer and state readable
  assign deploy_pending = q.pend;
  assign expire_timer = q.exp_cnt;
  assign chan_deploy_misuse_flag = q.misuse;
  assign chan_deploy_done_flag = q.done;
  assign any_deploy_done_flag = q.any_done;
  assign chan_fault_latched = q.flt_latch;
  assign global_fire_on = (q.gfe == sqd_pkg::GFE_ON);
  assign diag_force_reset = q.diag_force;
  assign arm_stretch_status_reg = q.str_stat;
  assign hs_enable = q.hs_en;
  assign ls_enable = q.ls_en;

endmodule

// [testbench/sqd_deploy_ctrl_props.sv]
// Port-level checks of the squib deploy control block
`timescale 1ns/1ps
module sqd_deploy_ctrl_props #(
  parameter int unsigned P_DUR_500 = sqd_pkg::DUR_500US_CYC,
  parameter int unsigned P_DUR_700 = sqd_pkg::DUR_700US_CYC,
  parameter int unsigned P_DUR_2MS = sqd_pkg::DUR_2MS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Commands
  input wire logic global_fire_enable_cmd,
  input wire logic global_fire_enable_signal,
  input wire logic deploy_command_wr,
  input wire logic deploy_config_wr,
  input wire logic [3:0] deploy_config_chan,
  input wire logic deploy_config_cur_hi,
  input wire logic [1:0] deploy_config_dur,
  // Observed outputs
  input wire logic [3:0] hs_drive,
  input wire logic [3:0] ls_drive,
  input wire logic [3:0] chan_cur_hi,
  input wire logic [3:0] deploy_pending,
  input wire logic [5:0] expire_timer,
  input wire logic [3:0] chan_deploy_misuse_flag,
  input wire logic [3:0] chan_deploy_done_flag,
  input wire logic any_deploy_done_flag,
  input wire logic global_fire_on,
  input wire logic diag_force_reset,
  input wire logic hs_enable,
  input wire logic ls_enable
);
  logic [3:0] hs_prev_q, new_fire;
  logic [17:0] hs_len_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Previous drive and channel 0 on-time
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_prev_q <= 4'h0;
      hs_len_q <= 18'h00000;
    end
    else
    begin
      hs_prev_q <= hs_drive;
      hs_len_q <= hs_drive[0] ? hs_len_q + 18'h00001 : 18'h00000;
    end
  end
  assign new_fire = hs_drive & ~hs_prev_q;
  chk_fire_global: assert property (
    (|new_fire) |-> ($past(global_fire_on) || $past(global_fire_on, 2)))
    else $error("fire while global off");
  chk_fire_pending: assert property (
    (new_fire & ~$past(deploy_pending, 2)) == 4'h0) else $error("firing without command");
  chk_fire_enabled: assert property (
    (|new_fire) |-> ($past(hs_enable, 2) || $past(hs_enable, 3))
      && ($past(ls_enable, 2) || $past(ls_enable, 3))) else $error("firing without enables");
  chk_ls_delay: assert property (
    $fell(hs_drive[0]) && ls_drive[0] |-> ls_drive[0] [*3] ##1 !ls_drive[0])
    else $error("low side delay wrong");
  chk_fire_length: assert property (
    $fell(hs_drive[0]) && ls_drive[0] |->
      (hs_len_q == P_DUR_500) || (hs_len_q == P_DUR_700) || (hs_len_q == P_DUR_2MS))
    else $error("high side on-time wrong");
  chk_done_set: assert property (
    $fell(hs_drive[0]) && ls_drive[0] |-> ##[0:1] chan_deploy_done_flag[0])
    else $error("done flag not set");
  chk_any_done: assert property (
    (|chan_deploy_done_flag) |-> ##[0:1] any_deploy_done_flag) else $error("global done missing");
  chk_diag_forced: assert property (
    global_fire_on |-> diag_force_reset) else $error("diagnostics not forced");
  chk_misuse_sub: assert property (
    deploy_config_wr && deploy_config_cur_hi && deploy_config_dur == 2'h2 |=>
      ((chan_deploy_misuse_flag & $past(deploy_config_chan)) == $past(deploy_config_chan))
      && ((chan_cur_hi & $past(deploy_config_chan)) == 4'h0)) else $error("misuse not replaced");
  chk_cmd_ignored: assert property (
    deploy_command_wr && !global_fire_on && deploy_pending == 4'h0 && !global_fire_enable_cmd
      |=> deploy_pending == 4'h0) else $error("command taken while off");
  chk_global_cmd: assert property (
    global_fire_enable_cmd |=> global_fire_on == $past(global_fire_enable_signal))
    else $error("global command ignored");
  chk_global_hold: assert property (
    !global_fire_enable_cmd |=> global_fire_on == $past(global_fire_on))
    else $error("global enable moved alone");
  chk_expire_clear: assert property (
    $past(expire_timer) == 6'h01 && expire_timer == 6'h00 |-> deploy_pending == 4'h0)
    else $error("pending left at expiry");
endmodule
bind sqd_deploy_ctrl sqd_deploy_ctrl_props #(
  .P_DUR_500(P_DUR_500), .P_DUR_700(P_DUR_700), .P_DUR_2MS(P_DUR_2MS)
) u_sqd_deploy_ctrl_props (
  .core_clk, .resetn, .global_fire_enable_cmd, .global_fire_enable_signal, .deploy_command_wr,
  .deploy_config_wr, .deploy_config_chan, .deploy_config_cur_hi, .deploy_config_dur,
  .hs_drive, .ls_drive, .chan_cur_hi, .deploy_pending, .expire_timer, .chan_deploy_misuse_flag,
  .chan_deploy_done_flag, .any_deploy_done_flag, .global_fire_on, .diag_force_reset,
  .hs_enable, .ls_enable
);

// [testbench/sqd_squib_load.sv]
// Squib loads with a switchable short to battery per channel
`timescale 1ns/1ps
module sqd_squib_load (
  // Driver states and fault setting
  input wire logic [3:0] hs_drive,
  input wire logic [3:0] ls_drive,
  input wire logic [3:0] short_bat,
  // Low-side current limit comparators
  output logic [3:0] ls_ilim_in
);
  always_comb ls_ilim_in = (hs_drive | ls_drive) & ls_drive & short_bat;
endmodule

// [testbench/sqd_deploy_ctrl_tb.sv]
// Self-checking bench for the squib deploy control block
`timescale 1ns/1ps
module sqd_deploy_ctrl_tb;
  localparam int unsigned D500 = 40, D700 = 50, D2MS = 300, TICK = 20, STR = 30;
  logic core_clk, resetn, por_ok, safing_state_machine_ok, use_internal_safing;
  logic arm_hs_pulse, arm_ls_pulse, hs_fire_enable_in, ls_fire_enable_n_in;
  logic deploy_command_wr, global_fire_enable_cmd, global_fire_enable_signal;
  logic deploy_config_wr, deploy_config_cur_hi, any_deploy_done_flag, global_fire_on;
  logic diag_force_reset, hs_enable, ls_enable;
  logic [1:0] deploy_config_dur, arm_stretch_status_reg;
  logic [3:0] ls_ilim_in, deploy_command_reg, deploy_config_chan, misuse_clr, short_bat, first;
  logic [3:0] hs_drive, ls_drive, chan_cur_hi, deploy_pending, chan_deploy_misuse_flag;
  logic [3:0] chan_deploy_done_flag, chan_fault_latched;
  logic [5:0] deploy_config_hold, expire_timer;
  int num_errors = 0, checks_done = 0, len;
  sqd_deploy_ctrl #(.P_DUR_500(D500), .P_DUR_700(D700), .P_DUR_2MS(D2MS), .P_EXP_TICK(TICK),
    .P_ARM_STRETCH(STR), .P_DEL_LS(3)) u_sqd_deploy_ctrl (.*);
  sqd_squib_load u_sqd_squib_load (.hs_drive, .ls_drive, .short_bat, .ls_ilim_in);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic conclude;
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Kind 0 global, 1 command, 2 config, 3 misuse clear
  task automatic send(input int k, input logic [3:0] bits, input logic [5:0] v);
    @(posedge core_clk);
    global_fire_enable_cmd <= (k == 0);
    global_fire_enable_signal <= bits[0];
    deploy_command_wr <= (k == 1);
    deploy_command_reg <= bits;
    deploy_config_hold <= v;
    deploy_config_wr <= (k == 2);
    deploy_config_chan <= bits;
    {deploy_config_cur_hi, deploy_config_dur} <= v[2:0];
    misuse_clr <= (k == 3) ? bits : 4'h0;
    @(posedge core_clk);
    {global_fire_enable_cmd, deploy_command_wr, deploy_config_wr} <= 3'h0;
    misuse_clr <= 4'h0;
    @(negedge core_clk);
  endtask
  // Waits for a firing and counts its high-side on-time
  task automatic fire_len(input int ch, output int n, output logic [3:0] at_rise);
    n = 0;
    for (int i = 0; i < 600 && hs_drive[ch] !== 1'b1; i++)
      @(negedge core_clk);
    if (hs_drive[ch] !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
    at_rise = hs_drive;
    while (hs_drive[ch] === 1'b1 && n < 600)
    begin
      n++;
      @(negedge core_clk);
    end
  endtask
  initial
  begin
    {use_internal_safing, arm_hs_pulse, arm_ls_pulse, hs_fire_enable_in, deploy_command_wr} = '0;
    {global_fire_enable_cmd, global_fire_enable_signal, deploy_config_wr} = '0;
    {deploy_config_cur_hi, deploy_config_dur, deploy_command_reg, deploy_config_chan} = '0;
    {misuse_clr, short_bat, deploy_config_hold} = '0;
    ls_fire_enable_n_in = 1'b1;
    por_ok = 1'b1;
    safing_state_machine_ok = 1'b1;
    resetn = 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk("drives after reset", 8'h00, {hs_drive, ls_drive});
    chk("global after reset", 8'h00, {6'h00, global_fire_on, diag_force_reset});
    send(1, 4'h1, 6'h02);
    chk("pending while off", 8'h00, {4'h0, deploy_pending});
    send(0, 4'h1, 6'h00);
    chk("global on and diag", 8'h03, {6'h00, global_fire_on, diag_force_reset});
    send(1, 4'h1, 6'h02);
    chk("pending and timer", 8'h12, {deploy_pending, expire_timer[3:0]});
    repeat (TICK) @(negedge core_clk);
    chk("pending mid hold", 8'h01, {4'h0, deploy_pending});
    repeat (TICK + 4) @(negedge core_clk);
    chk("expired unarmed", 8'h00, {deploy_pending, hs_drive});
    send(2, 4'hF, 6'h06);
    chk("misuse replaced", 8'hF0, {chan_deploy_misuse_flag, chan_cur_hi});
    @(posedge core_clk);
    por_ok <= 1'b0;
    {hs_fire_enable_in, ls_fire_enable_n_in} <= 2'h2;
    send(1, 4'h8, 6'h3F);
    repeat (20) @(negedge core_clk);
    chk("no fire without power", 8'h00, {hs_drive, ls_drive});
    chk("pin enables", 8'h03, {6'h00, hs_enable, ls_enable});
    @(posedge core_clk);
    por_ok <= 1'b1;
    fire_len(3, len, first);
    chk("late enable fire length", 8'(D500), 8'(len));
    repeat (5) @(negedge core_clk);
    chk("done flags", 8'h81, {chan_deploy_done_flag, 3'h0, any_deploy_done_flag});
    send(3, 4'hF, 6'h00);
    chk("misuse cleared", 8'h00, {chan_deploy_misuse_flag, 4'h0});
    send(1, 4'h5, 6'h3F);
    fire_len(0, len, first);
    chk("joint start", 8'h05, {4'h0, first});
    chk("joint length", 8'(D500), 8'(len));
    send(1, 4'h1, 6'h01);
    repeat (TICK + 5) @(negedge core_clk);
    chk("refire refused", 8'h00, {hs_drive, ls_drive});
    send(0, 4'h0, 6'h00);
    send(0, 4'h1, 6'h00);
    send(1, 4'h1, 6'h3F);
    fork
      begin
        repeat (10) @(negedge core_clk);
        send(0, 4'h0, 6'h00);
      end
      fire_len(0, len, first);
    join
    chk("fire survives global off", 8'(D500), 8'(len));
    send(0, 4'h1, 6'h00);
    send(2, 4'h2, 6'h02);
    @(posedge core_clk);
    short_bat <= 4'h2;
    send(1, 4'h2, 6'h3F);
    fire_len(1, len, first);
    chk("fault kills both", 8'h00, {hs_drive, ls_drive});
    chk("fault latch", 8'h2D, {chan_fault_latched, chan_deploy_done_flag});
    chk("fault cut short", 8'h01, 8'(len < D2MS));
    send(0, 4'h0, 6'h00);
    send(0, 4'h1, 6'h00);
    send(2, 4'h4, 6'h05);
    chk("fault cleared and current", 8'h04, {chan_fault_latched, chan_cur_hi});
    send(1, 4'h4, 6'h3F);
    fire_len(2, len, first);
    chk("long pulse length", 8'(D700), 8'(len));
    @(posedge core_clk);
    {hs_fire_enable_in, ls_fire_enable_n_in, short_bat} <= 6'h10;
    use_internal_safing <= 1'b1;
    {arm_hs_pulse, arm_ls_pulse} <= 2'h3;
    @(posedge core_clk);
    {arm_hs_pulse, arm_ls_pulse} <= 2'h0;
    repeat (3) @(negedge core_clk);
    chk("stretch active", 8'h0F, {4'h0, arm_stretch_status_reg, hs_enable, ls_enable});
    repeat (STR + 6) @(negedge core_clk);
    chk("stretch ended", 8'h00, {4'h0, arm_stretch_status_reg, hs_enable, ls_enable});
    conclude();
  end
endmodule
